// [rtl/scr_pkg.sv]
package scr_pkg;

   typedef enum logic [2:0] {
      SCR_RUN   = 3'h1,
      SCR_SLEEP = 3'h2,
      SCR_DEEP  = 3'h4
   } scr_power_e;

   typedef struct packed {
      logic       wfe_exec;
      logic       sev_exec;
      logic       ext_event;
      logic       irq_pend_new;
      logic       irq_pend_enabled;
      logic       return_to_thread;
   } scr_core_ev_s;

   typedef struct packed {
      logic       sleeping;
      logic       deep_sleep;
      logic       wake;
   } scr_power_s;

   typedef logic [1:0] scr_pri_t;

endpackage

// [rtl/scr_regs.svh]
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH

`define SCR_OFF_INT_RST_CTRL    12'h00c
`define SCR_OFF_LOW_POWER_CTRL  12'h010
`define SCR_OFF_CORE_CONFIG     12'h014
`define SCR_OFF_HANDLER_PRI_TWO 12'h01c
`define SCR_OFF_HANDLER_PRI_THR 12'h020

`define SCR_WRITE_KEY           16'h05fa
`define SCR_KEY_HI              31
`define SCR_KEY_LO              16
`define SCR_BIT_BYTE_ORDER      15
`define SCR_BIT_SYS_RST_REQ     2
`define SCR_BIT_DBG_ACT_CLR     1

`define SCR_BIT_WAKE_ON_PEND    4
`define SCR_BIT_DEEP_SLEEP      2
`define SCR_BIT_SLEEP_AFTER     1

`define SCR_BIT_STACK_ALIGN     9
`define SCR_BIT_MISALIGN_TRAP   3

`define SCR_PRI_SVC_HI          31
`define SCR_PRI_SVC_LO          30
`define SCR_PRI_TICK_HI         31
`define SCR_PRI_TICK_LO         30
`define SCR_PRI_PEND_HI         23
`define SCR_PRI_PEND_LO         22

`define SCR_ADDR_HI             11
`define SCR_ADDR_LO             2

`endif

// [rtl/scr_system_control_regs.sv]
`timescale 1ns/1ns
`include "scr_regs.svh"

module scr_system_control_regs #(
   parameter bit TICK_TIMER_PRESENT = 1'b1
) (
   input  wire logic                 clk_sys_i,
   input  wire logic                 resetn_i,
   input  wire logic                 psel_i,
   input  wire logic                 penable_i,
   input  wire logic                 pwrite_i,
   input  wire logic [11:0]          paddr_i,
   input  wire logic [31:0]          pwdata_i,
   output logic      [31:0]          prdata_o,
   output logic                      pready_o,
   output logic                      pslverr_o,
   input  wire scr_pkg::scr_core_ev_s core_ev_i,
   input  wire logic                 misaligned_access_i,
   input  wire logic                 exc_entry_i,
   input  wire logic                 exc_return_i,
   input  wire logic                 stack_realign_i,
   output logic                      stacked_align_bit_o,
   output logic                      restore_realign_o,
   output logic                      hard_fault_req_o,
   output scr_pkg::scr_power_s       power_o,
   output logic                      system_reset_request_o,
   output scr_pkg::scr_pri_t         supervisor_call_priority_o,
   output scr_pkg::scr_pri_t         pendable_service_priority_o,
   output scr_pkg::scr_pri_t         tick_timer_priority_o
);

   logic              wake_on_pending_ff;
   logic              deep_sleep_select_ff;
   logic              sleep_after_handler_ff;
   logic              rst_req_ff;
   logic              event_latch_ff;
   logic              saved_align_ff;
   logic              fault_ff;
   scr_pkg::scr_pri_t svc_pri_ff;
   scr_pkg::scr_pri_t pend_pri_ff;
   scr_pkg::scr_pri_t tick_pri_ff;
   scr_pkg::scr_power_e state_ff;
   scr_pkg::scr_power_e nxt_state;
   logic [31:0]       nxt_rdata;
   logic              wr_en;
   logic              rd_en;
   logic              key_ok;
   logic              wake_ev;
   logic              mapped;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a[`SCR_ADDR_HI:`SCR_ADDR_LO] == off[`SCR_ADDR_HI:`SCR_ADDR_LO]);
   endfunction

   assign wr_en     = psel_i && penable_i && pwrite_i;
   assign rd_en     = psel_i && !penable_i && !pwrite_i;
   assign pready_o  = 1'b1;
   assign mapped    = hit(paddr_i, `SCR_OFF_INT_RST_CTRL) || hit(paddr_i, `SCR_OFF_LOW_POWER_CTRL)
                   || hit(paddr_i, `SCR_OFF_CORE_CONFIG) || hit(paddr_i, `SCR_OFF_HANDLER_PRI_TWO)
                   || hit(paddr_i, `SCR_OFF_HANDLER_PRI_THR);
   assign pslverr_o = psel_i && penable_i && !mapped;

   assign key_ok = (pwdata_i[`SCR_KEY_HI:`SCR_KEY_LO] == `SCR_WRITE_KEY);

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_req_ff <= 1'b0;
      end else if (wr_en && hit(paddr_i, `SCR_OFF_INT_RST_CTRL) && key_ok
                   && pwdata_i[`SCR_BIT_SYS_RST_REQ]) begin
         rst_req_ff <= 1'b1;
      end
   end
   assign system_reset_request_o = rst_req_ff;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wake_on_pending_ff     <= 1'b0;
         deep_sleep_select_ff   <= 1'b0;
         sleep_after_handler_ff <= 1'b0;
      end else if (wr_en && hit(paddr_i, `SCR_OFF_LOW_POWER_CTRL)) begin
         wake_on_pending_ff     <= pwdata_i[`SCR_BIT_WAKE_ON_PEND];
         deep_sleep_select_ff   <= pwdata_i[`SCR_BIT_DEEP_SLEEP];
         sleep_after_handler_ff <= pwdata_i[`SCR_BIT_SLEEP_AFTER];
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         svc_pri_ff  <= 2'h0;
         pend_pri_ff <= 2'h0;
         tick_pri_ff <= 2'h0;
      end else if (wr_en && hit(paddr_i, `SCR_OFF_HANDLER_PRI_TWO)) begin
         svc_pri_ff <= pwdata_i[`SCR_PRI_SVC_HI:`SCR_PRI_SVC_LO];
      end else if (wr_en && hit(paddr_i, `SCR_OFF_HANDLER_PRI_THR)) begin
         pend_pri_ff <= pwdata_i[`SCR_PRI_PEND_HI:`SCR_PRI_PEND_LO];
         tick_pri_ff <= TICK_TIMER_PRESENT ? pwdata_i[`SCR_PRI_TICK_HI:`SCR_PRI_TICK_LO] : 2'h0;
      end
   end
   assign supervisor_call_priority_o  = svc_pri_ff;
   assign pendable_service_priority_o = pend_pri_ff;
   assign tick_timer_priority_o       = tick_pri_ff;

   assign wake_ev = core_ev_i.irq_pend_enabled
                 || (wake_on_pending_ff && core_ev_i.irq_pend_new)
                 || core_ev_i.sev_exec || core_ev_i.ext_event;

   // event latch, set wins over consume
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         event_latch_ff <= 1'b0;
      end else if (wake_ev && state_ff == scr_pkg::SCR_RUN) begin
         event_latch_ff <= 1'b1;
      end else if (core_ev_i.wfe_exec && state_ff == scr_pkg::SCR_RUN) begin
         event_latch_ff <= 1'b0;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         scr_pkg::SCR_RUN: begin
            if ((core_ev_i.wfe_exec && !event_latch_ff && !wake_ev)
                || (sleep_after_handler_ff && core_ev_i.return_to_thread)) begin
               nxt_state = deep_sleep_select_ff ? scr_pkg::SCR_DEEP : scr_pkg::SCR_SLEEP;
            end
         end
         scr_pkg::SCR_SLEEP,
         scr_pkg::SCR_DEEP: begin
            if (wake_ev) begin
               nxt_state = scr_pkg::SCR_RUN;
            end
         end
         default: nxt_state = scr_pkg::SCR_RUN;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff <= scr_pkg::SCR_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         power_o <= '0;
      end else begin
         power_o.sleeping   <= (nxt_state != scr_pkg::SCR_RUN);
         power_o.deep_sleep <= (nxt_state == scr_pkg::SCR_DEEP);
         power_o.wake       <= (state_ff != scr_pkg::SCR_RUN) && (nxt_state == scr_pkg::SCR_RUN);
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         saved_align_ff      <= 1'b0;
         stacked_align_bit_o <= 1'b0;
         restore_realign_o   <= 1'b0;
      end else begin
         if (exc_entry_i) begin
            saved_align_ff      <= stack_realign_i;
            stacked_align_bit_o <= stack_realign_i;
         end
         restore_realign_o <= exc_return_i && saved_align_ff;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fault_ff <= 1'b0;
      end else begin
         fault_ff <= misaligned_access_i;
      end
   end
   assign hard_fault_req_o = fault_ff;

   always_comb begin
      nxt_rdata = 32'h0;
      if (hit(paddr_i, `SCR_OFF_INT_RST_CTRL)) begin
         nxt_rdata[`SCR_BIT_BYTE_ORDER]  = 1'b0;
         nxt_rdata[`SCR_BIT_SYS_RST_REQ] = 1'b0;
         nxt_rdata[`SCR_BIT_DBG_ACT_CLR] = 1'b0;
      end else if (hit(paddr_i, `SCR_OFF_LOW_POWER_CTRL)) begin
         nxt_rdata[`SCR_BIT_WAKE_ON_PEND] = wake_on_pending_ff;
         nxt_rdata[`SCR_BIT_DEEP_SLEEP]   = deep_sleep_select_ff;
         nxt_rdata[`SCR_BIT_SLEEP_AFTER]  = sleep_after_handler_ff;
      end else if (hit(paddr_i, `SCR_OFF_CORE_CONFIG)) begin
         nxt_rdata[`SCR_BIT_STACK_ALIGN]   = 1'b1;
         nxt_rdata[`SCR_BIT_MISALIGN_TRAP] = 1'b1;
      end else if (hit(paddr_i, `SCR_OFF_HANDLER_PRI_TWO)) begin
         nxt_rdata[`SCR_PRI_SVC_HI:`SCR_PRI_SVC_LO] = svc_pri_ff;
      end else if (hit(paddr_i, `SCR_OFF_HANDLER_PRI_THR)) begin
         nxt_rdata[`SCR_PRI_TICK_HI:`SCR_PRI_TICK_LO] = tick_pri_ff;
         nxt_rdata[`SCR_PRI_PEND_HI:`SCR_PRI_PEND_LO] = pend_pri_ff;
      end
   end

   // Read data is captured in the setup cycle so it stands from flip-flops in the access cycle.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prdata_o <= 32'h0;
      end else if (rd_en) begin
         prdata_o <= nxt_rdata;
      end
   end

endmodule

// [tb/scr_regs_assertions.sv]
`timescale 1ns/1ns
module scr_regs_chk (
   input wire logic                 clk_sys_i,
   input wire logic                 resetn_i,
   input wire logic                 psel_i,
   input wire logic                 penable_i,
   input wire logic                 pwrite_i,
   input wire logic [11:0]          paddr_i,
   input wire logic [31:0]          pwdata_i,
   input wire logic [31:0]          prdata_o,
   input wire scr_pkg::scr_core_ev_s core_ev_i,
   input wire scr_pkg::scr_power_s   power_o,
   input wire logic                 system_reset_request_o,
   input wire logic                 misaligned_access_i,
   input wire logic                 hard_fault_req_o,
   input wire logic                 exc_entry_i,
   input wire logic                 stack_realign_i,
   input wire logic                 stacked_align_bit_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   logic rd;
   logic wr;
   assign rd = psel_i && !penable_i && !pwrite_i;
   assign wr = psel_i && penable_i && pwrite_i && paddr_i == 12'h00c;
   sequence s_nap; power_o.sleeping && core_ev_i.ext_event; endsequence
   sequence s_up; !power_o.sleeping && power_o.wake ##1 !power_o.wake; endsequence
   property p_key; wr && pwdata_i[31:16] != 16'h05fa && !system_reset_request_o |=> !system_reset_request_o; endproperty
   a_key: assert property (p_key) else $error("reset request after a bad key");
   property p_go; wr && pwdata_i[31:16] == 16'h05fa && pwdata_i[2] |=> system_reset_request_o; endproperty
   a_go: assert property (p_go) else $error("keyed reset request lost");
   property p_hold; system_reset_request_o |=> system_reset_request_o; endproperty
   a_hold: assert property (p_hold) else $error("reset request dropped");
   property p_fault; 1 |=> hard_fault_req_o == $past(misaligned_access_i); endproperty
   a_fault: assert property (p_fault) else $error("hard fault pulse wrong");
   property p_wake; s_nap |=> s_up; endproperty
   a_wake: assert property (p_wake) else $error("external event did not wake");
   property p_ctl; rd && paddr_i == 12'h00c |=> prdata_o == 32'h0; endproperty
   a_ctl: assert property (p_ctl) else $error("reset control read not zero");
   property p_ccr; rd && paddr_i == 12'h014 |=> prdata_o == 32'h208; endproperty
   a_ccr: assert property (p_ccr) else $error("config read wrong");
   property p_pri; rd && paddr_i == 12'h01c |=> prdata_o[29:0] == 30'h0; endproperty
   a_pri: assert property (p_pri) else $error("priority two low bits set");
   property p_stk; exc_entry_i && stack_realign_i |=> stacked_align_bit_o; endproperty
   a_stk: assert property (p_stk) else $error("stacked align bit lost");
endmodule

bind scr_system_control_regs scr_regs_chk u_chk (.clk_sys_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
   .pwdata_i, .prdata_o, .core_ev_i, .power_o, .system_reset_request_o, .misaligned_access_i, .hard_fault_req_o,
   .exc_entry_i, .stack_realign_i, .stacked_align_bit_o);

// [tb/system_control_regs_tb.sv]
`timescale 1ns/1ns
module system_control_regs_tb;
   logic                 clk_sys_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic                 misaligned_access_i = 0, exc_entry_i = 0, exc_return_i = 0, stack_realign_i = 0;
   logic                 pready_o, pslverr_o, e, stacked_align_bit_o, restore_realign_o;
   logic                 hard_fault_req_o, system_reset_request_o;
   logic [11:0]          paddr_i = '0;
   logic [31:0]          pwdata_i = '0, prdata_o, r, d;
   scr_pkg::scr_core_ev_s core_ev_i = '0;
   scr_pkg::scr_power_s  power_o;
   scr_pkg::scr_pri_t    supervisor_call_priority_o, pendable_service_priority_o, tick_timer_priority_o;
   int                   fail_count = 0, check_count = 0;
   logic [11:0]          adr [5] = '{12'h00c, 12'h010, 12'h014, 12'h01c, 12'h020};
   // Rows: low power control value, event pulse, expected power state.
   logic [13:0]          tbl [16] = '{{5'h4, 6'h20, 3'h6}, {5'h4, 6'h08, 3'h1}, {5'h0, 6'h20, 3'h4}, {5'h0, 6'h04, 3'h4},
      {5'h0, 6'h02, 3'h1}, {5'h10, 6'h20, 3'h4}, {5'h10, 6'h04, 3'h1}, {5'h0, 6'h20, 3'h4}, {5'h0, 6'h10, 3'h1},
      {5'h2, 6'h01, 3'h4}, {5'h2, 6'h08, 3'h1}, {5'h0, 6'h01, 3'h0}, {5'h0, 6'h02, 3'h0}, {5'h0, 6'h20, 3'h0},
      {5'h0, 6'h20, 3'h4}, {5'h0, 6'h08, 3'h1}};

   always #5 clk_sys_i = ~clk_sys_i;

   scr_system_control_regs u_dut (.clk_sys_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .core_ev_i, .misaligned_access_i, .exc_entry_i, .exc_return_i,
      .stack_realign_i, .stacked_align_bit_o, .restore_realign_o, .hard_fault_req_o, .power_o,
      .system_reset_request_o, .supervisor_call_priority_o, .pendable_service_priority_o, .tick_timer_priority_o);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] expect_rd(input logic [11:0] a, input logic [31:0] w);
      case (a)
         12'h010: return w & 32'h16;
         12'h014: return 32'h208;
         12'h01c: return w & 32'hc000_0000;
         12'h020: return w & 32'hc0c0_0000;
         default: return 32'h0;
      endcase
   endfunction

   // Writes are masked per register; debug bits go out as zero, but reserved bits 29:24 of 0x01c and 29:24, 21:16 of 0x020 are left random.
   function automatic logic [31:0] wmask(input logic [11:0] a);
      case (a)
         12'h00c: return 32'hffff_0004;
         12'h010: return 32'h0000_0016;
         12'h014: return 32'h0000_0208;
         12'h01c: return 32'hff00_0000;
         12'h020: return 32'hffff_0000;
         default: return 32'h0;
      endcase
   endfunction

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_sys_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge clk_sys_i);
      penable_i <= 1;
      @(posedge clk_sys_i);
      while (pready_o !== 1'b1) @(posedge clk_sys_i);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask

   task automatic summarize();
      if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #100000;
      fail_count++;
      summarize();
   end

   initial begin
      r = $urandom(32'hfddeb0fb);
      repeat (20) @(posedge clk_sys_i);
      resetn_i <= 1;
      foreach (adr[i]) begin
         apb(0, adr[i], 0);
         check(r, expect_rd(adr[i], 0));
      end
      repeat (6) foreach (adr[i]) begin
         d = $urandom & wmask(adr[i]);
         if (d[31:16] == 16'h05fa) d[16] = 0;
         apb(1, adr[i], d);
         apb(0, adr[i], 0);
         check(r, expect_rd(adr[i], d));
      end
      d = $urandom;
      apb(1, 12'h01c, d);
      apb(1, 12'h020, ~d & 32'hffff_0000);
      #1;
      check({supervisor_call_priority_o, pendable_service_priority_o, tick_timer_priority_o},
            {d[31:30], ~d[23:22], ~d[31:30]});
      apb(1, 12'h104, '1);
      check(e, 1);
      apb(0, 12'h104, 0);
      check({e, r[30:0]}, 32'h8000_0000);
      foreach (tbl[i]) begin
         apb(1, 12'h010, {27'h0, tbl[i][13:9]});
         @(posedge clk_sys_i);
         core_ev_i <= tbl[i][8:3];
         @(posedge clk_sys_i);
         core_ev_i <= '0;
         #1;
         check(power_o, tbl[i][2:0]);
      end
      @(posedge clk_sys_i);
      misaligned_access_i <= 1;
      exc_entry_i <= 1;
      stack_realign_i <= 1;
      @(posedge clk_sys_i);
      {misaligned_access_i, exc_entry_i, stack_realign_i} <= 3'h0;
      exc_return_i <= 1;
      #1;
      check({hard_fault_req_o, stacked_align_bit_o}, 2'b11);
      @(posedge clk_sys_i);
      exc_return_i <= 0;
      #1;
      check(restore_realign_o, 1);
      apb(1, 12'h00c, 32'h05fb_0004);
      #1;
      check(system_reset_request_o, 0);
      apb(1, 12'h00c, 32'h05fa_0004);
      #1;
      check(system_reset_request_o, 1);
      apb(0, 12'h00c, 0);
      check(r, 0);
      @(posedge clk_sys_i);
      resetn_i <= 0;
      repeat (2) @(posedge clk_sys_i);
      resetn_i <= 1;
      #1;
      check(system_reset_request_o, 0);
      summarize();
   end
endmodule
